// file: include/gpio_port_consts.svh
// Purpose: register offsets, reset values and field positions of the gpio port
// Assumes: byte-wide registers on a plain address/strobe port
// Notes: the sensitivity field models the separate miscellaneous register bits
// Function
// [RL1] eight pins, each input with or without interrupt, or output.
// [RL2] register bit n controls or reflects pin n, no reordering.
// [RL3] direction zero makes an input; data read returns the pin level.
// [RL4] data write on an input updates the latch only; pin stays undriven.
// [RL5] software writes the latch before turning a pin into an output.
// [RL6] an input with interrupt raises an external request on an event.
// [RL7] edge or level sensitivity is chosen by software sensitivity bits.
// [RL8] enabled pins of a group are ANDed before detection; one low masks all.
// [RL9] request latch is hidden from software and clears on vector fetch.
// [RL10] writing the sensitivity bits clears a pending request.
// [RL11] output option picks push-pull or open drain; one floats in open drain.
// [RL12] output mode: writes drive through the latch, reads return the pin.
// [RL13] software avoids read-modify-write on open-drain data, uses a shadow.
// [RL14] an enabled peripheral function overrides direction, option and data; the code overrides them only where the function also sets out_en.
// [RL15] a peripheral driving a pin makes it an output of the required form.
// [RL16] software leaves a peripheral input pin as input; it stays readable.
// [RL17] a bidirectional peripheral pin is left a floating input by software.
// [RL18] software never enables a function on a pin set as interrupt input.
// [RL19] an analog input pin is a floating input, steady during conversion.
// [RL20] input pin driven by its function reads back the function output.
// [RL21] output pin used as function input gives the peripheral the latch value.
// [RL22] direction bit zero is input, one is output, software only.
// [RL23] option: input 0 floating, 1 with interrupt; output 0 open drain, 1 push-pull.
// [RL24] data, direction and option reset to zero: floating inputs, no interrupt.
// [RL25] combined group input is synchronised before edge or level detection.
`ifndef GPIO_PORT_CONSTS_SVH
`define GPIO_PORT_CONSTS_SVH
`define GPIO_ADDR_W 2
`define GPIO_OFS_DATA 2'h0
`define GPIO_OFS_DIR 2'h1
`define GPIO_OFS_OPT 2'h2
`define GPIO_OFS_SENS 2'h3
`define GPIO_RST_BYTE 8'h00
`define GPIO_RST_SENS 2'h0
`define GPIO_SENS_LSB 0
`define GPIO_SENS_W 2
`endif

// file: include/gpio_port_pkg.sv
// Purpose: types shared by the gpio port files
// Assumes: nothing
// Notes: sensitivity codes select falling, rising, both edges or low level
package gpio_port_pkg;
    typedef enum logic [1:0] {
        SENS_FALL_LOW,
        SENS_RISE,
        SENS_FALL,
        SENS_BOTH
    } sens_e;

    typedef struct packed {
        logic [7:0] pin_o;
        logic [7:0] pin_oe;
    } pad_drive_s;

    typedef struct packed {
        logic [7:0] enable;
        logic [7:0] out_val;
        logic [7:0] out_en;
        logic [7:0] open_drain;
    } alt_ctrl_s;
endpackage

// file: design/gpio_irq_detect.sv
// Purpose: synchronise the combined group level and detect the sensitivity event
// Assumes: group level is asynchronous to clk_i
// Notes: request latch clears on vector fetch or sensitivity change
`timescale 1ns/10ps
module gpio_irq_detect (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic group_level_i,
    input wire gpio_port_pkg::sens_e sens_i,
    input wire logic sens_wr_i,
    input wire logic vec_fetch_i,
    output logic req_o
);
    logic sync1_q;
    logic sync2_q;
    logic prev_q;
    logic event_w;
    logic rise_w;
    logic fall_w;

    // first stage feeds only the second
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            sync1_q <= group_level_i; // RL25
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    assign rise_w = sync2_q & ~prev_q;
    assign fall_w = ~sync2_q & prev_q;

    always_comb begin
        case (sens_i) // RL7
            gpio_port_pkg::SENS_FALL_LOW: event_w = fall_w | ~sync2_q;
            gpio_port_pkg::SENS_RISE: event_w = rise_w;
            gpio_port_pkg::SENS_FALL: event_w = fall_w;
            gpio_port_pkg::SENS_BOTH: event_w = rise_w | fall_w;
            default: event_w = 1'b0;
        endcase
    end

    // sensitivity write discards a pending request and a new event; a new event wins over vector fetch
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_o <= 1'b0;
        end else if (event_w && !sens_wr_i) begin
            req_o <= 1'b1; // RL6
        end else if (sens_wr_i || vec_fetch_i) begin
            req_o <= 1'b0; // RL9 RL10
        end
    end
endmodule // gpio_irq_detect

// file: design/gpio_port.sv
// Purpose: eight-pin general purpose port with group external interrupt
// Assumes: byte registers on a plain strobe port, read data one cycle later
// Notes: pads resolved outside; pin_i is the level seen on each pad
`timescale 1ns/10ps
`include "gpio_port_consts.svh"
module gpio_port #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [`GPIO_ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] pin_o,
    output logic [WIDTH-1:0] pin_oe_o,
    input wire gpio_port_pkg::alt_ctrl_s alt_i,
    output logic [WIDTH-1:0] alt_in_o,
    input wire logic vec_fetch_i,
    output logic irq_req_o
);
    logic rst_s1_q;
    logic rst_n_q;
    logic [WIDTH-1:0] latch_q;
    logic [WIDTH-1:0] dir_q;
    logic [WIDTH-1:0] opt_q;
    logic [`GPIO_SENS_W-1:0] sens_q;
    logic [WIDTH-1:0] eff_out_w;
    logic [WIDTH-1:0] eff_val_w;
    logic [WIDTH-1:0] eff_od_w;
    logic [WIDTH-1:0] read_val_w;
    logic [WIDTH-1:0] irq_en_w;
    gpio_port_pkg::pad_drive_s drive_d;
    gpio_port_pkg::pad_drive_s drive_q;
    logic [7:0] rdata_d;
    logic [WIDTH-1:0] alt_in_d;
    logic group_level_w;
    logic sens_wr_w;
    logic wr_data_w;
    logic wr_dir_w;
    logic wr_opt_w;

    function automatic logic hit(input logic [`GPIO_ADDR_W-1:0] a,
                                 input logic [`GPIO_ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    // reset release through two flops
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    assign wr_data_w = wr_i & hit(addr_i, `GPIO_OFS_DATA);
    assign wr_dir_w = wr_i & hit(addr_i, `GPIO_OFS_DIR);
    assign wr_opt_w = wr_i & hit(addr_i, `GPIO_OFS_OPT);
    assign sens_wr_w = wr_i & hit(addr_i, `GPIO_OFS_SENS);

    // latch written in any direction so the level is ready when turned to output
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            latch_q <= WIDTH'(`GPIO_RST_BYTE); // RL24
            dir_q <= WIDTH'(`GPIO_RST_BYTE); // RL24
            opt_q <= WIDTH'(`GPIO_RST_BYTE); // RL24
            sens_q <= `GPIO_RST_SENS;
        end else begin
            if (wr_data_w) latch_q <= wdata_i[WIDTH-1:0]; // RL4
            if (wr_dir_w) dir_q <= wdata_i[WIDTH-1:0]; // RL22
            if (wr_opt_w) opt_q <= wdata_i[WIDTH-1:0]; // RL23
            if (sens_wr_w) sens_q <= wdata_i[`GPIO_SENS_LSB +: `GPIO_SENS_W]; // RL7
        end
    end

    // per-pin mode resolution; alternate function has priority where it also sets out_en
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_pin // RL1 RL2
            assign eff_out_w[g] = alt_i.enable[g] & alt_i.out_en[g] ? 1'b1 : dir_q[g]; // RL14 RL15
            assign eff_val_w[g] = alt_i.enable[g] & alt_i.out_en[g] ?
                                  alt_i.out_val[g] : latch_q[g];
            assign eff_od_w[g] = alt_i.enable[g] & alt_i.out_en[g] ?
                                 alt_i.open_drain[g] : ~opt_q[g]; // RL15
            // open drain drives only the low level
            assign drive_d.pin_o[g] = eff_val_w[g];
            assign drive_d.pin_oe[g] = eff_out_w[g] & (~eff_od_w[g] | ~eff_val_w[g]); // RL11 RL3
            // input pin with function driving reads function output
            assign read_val_w[g] = (~dir_q[g] & alt_i.enable[g] & alt_i.out_en[g]) ?
                                   alt_i.out_val[g] : pin_i[g]; // RL20 RL3 RL12
            // output pin feeds the latch value to the peripheral
            assign alt_in_d[g] = dir_q[g] ? latch_q[g] : pin_i[g]; // RL21 RL16
            assign irq_en_w[g] = ~dir_q[g] & opt_q[g]; // RL23
        end
    endgenerate

    // AND of enabled pins; a low pin masks the others
    assign group_level_w = &(pin_i | ~irq_en_w); // RL8

    always_comb begin
        rdata_d = 8'h00;
        case (addr_i)
            `GPIO_OFS_DATA: rdata_d[WIDTH-1:0] = read_val_w; // RL3 RL12
            `GPIO_OFS_DIR: rdata_d[WIDTH-1:0] = dir_q;
            `GPIO_OFS_OPT: rdata_d[WIDTH-1:0] = opt_q;
            `GPIO_OFS_SENS: rdata_d[`GPIO_SENS_LSB +: `GPIO_SENS_W] = sens_q;
            default: rdata_d = 8'h00;
        endcase
    end

    // registered pads: one cycle from register change to pin
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            drive_q <= '0;
            rdata_o <= 8'h00;
            alt_in_o <= '0;
        end else begin
            drive_q <= drive_d;
            rdata_o <= rd_i ? rdata_d : 8'h00;
            // peripheral sees its input one cycle late, traded for a flopped output
            alt_in_o <= alt_in_d;
        end
    end

    assign pin_o = drive_q.pin_o[WIDTH-1:0];
    assign pin_oe_o = drive_q.pin_oe[WIDTH-1:0];

    gpio_irq_detect u_irq (
        .clk_i(clk_i),
        .rst_n_i(rst_n_q),
        .group_level_i(group_level_w),
        .sens_i(gpio_port_pkg::sens_e'(sens_q)),
        .sens_wr_i(sens_wr_w), // RL10
        .vec_fetch_i(vec_fetch_i), // RL9
        .req_o(irq_req_o)
    );
endmodule // gpio_port

// file: verif/gpio_port_chk.sv
// Purpose: port-level checks of the gpio port
// Assumes: one clock; registers shadowed from bus writes
// Notes: pads assumed steady around data reads
`timescale 1ns/10ps
`include "gpio_port_consts.svh"
module gpio_port_chk #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [`GPIO_ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [WIDTH-1:0] pin_i,
    input wire logic [WIDTH-1:0] pin_o,
    input wire logic [WIDTH-1:0] pin_oe_o,
    input wire gpio_port_pkg::alt_ctrl_s alt_i,
    input wire logic [WIDTH-1:0] alt_in_o,
    input wire logic vec_fetch_i,
    input wire logic irq_req_o
);
    logic [7:0] dat_q, dir_q, opt_q;
    logic [1:0] sen_q;
    wire [7:0] ae = alt_i.enable & alt_i.out_en;
    wire grp = &(pin_i | ~(~dir_q & opt_q));
    wire sens_wr = wr_i && (addr_i == `GPIO_OFS_SENS);
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dat_q <= 8'h00;
            dir_q <= 8'h00;
            opt_q <= 8'h00;
            sen_q <= 2'h0;
        end else if (wr_i) begin
            if (addr_i == `GPIO_OFS_DATA) dat_q <= wdata_i;
            if (addr_i == `GPIO_OFS_DIR) dir_q <= wdata_i;
            if (addr_i == `GPIO_OFS_OPT) opt_q <= wdata_i;
            if (sens_wr) sen_q <= wdata_i[1:0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data not idle");
    AST_RD_PIN: assert property (rd_i && addr_i == `GPIO_OFS_DATA && alt_i.enable == 8'h00
        |=> rdata_o == $past(pin_i)) else $error("data read not pin level");
    AST_OE_IO: assert property ($past(alt_i.enable) == 8'h00
        |-> pin_oe_o == $past(dir_q & (opt_q | ~dat_q))) else $error("pin enable wrong");
    AST_OUT_VAL: assert property ($past(alt_i.enable) == 8'h00
        |-> (pin_oe_o & pin_o) == $past(dir_q & opt_q & dat_q)) else $error("pin drive wrong");
    AST_ALT_OE: assert property ((pin_oe_o & $past(ae))
        == $past(ae & ~(alt_i.open_drain & alt_i.out_val))) else $error("alt enable wrong");
    AST_ALT_VAL: assert property ((pin_oe_o & pin_o & $past(ae))
        == $past(ae & alt_i.out_val & ~alt_i.open_drain)) else $error("alt drive wrong");
    AST_ALT_IN: assert property (alt_in_o == $past((dir_q & dat_q) | (~dir_q & pin_i)))
        else $error("peripheral input wrong");
    AST_SENS_CLR: assert property (sens_wr |=> !irq_req_o)
        else $error("request not cleared");
    AST_IRQ_HOLD: assert property (irq_req_o && !vec_fetch_i && !sens_wr |=> irq_req_o)
        else $error("request dropped");
    AST_IRQ_RISE: assert property ($rose(irq_req_o) && sen_q == 2'h1 |-> $past(grp, 3))
        else $error("request without rising group");
    cover property ($rose(irq_req_o));
    cover property (vec_fetch_i && irq_req_o);
    cover property (rd_i && addr_i == `GPIO_OFS_DATA && ae != 8'h00);
endmodule // gpio_port_chk
bind gpio_port gpio_port_chk #(.WIDTH(WIDTH)) i_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .alt_i(alt_i), .alt_in_o(alt_in_o),
    .vec_fetch_i(vec_fetch_i), .irq_req_o(irq_req_o));

// file: verif/pad_model.sv
// Purpose: external circuitry on the eight port pads
// Assumes: device drive wins where its enable is high
// Notes: a released line with no external drive wanders every cycle
`timescale 1ns/10ps
module pad_model (
    input wire logic clk_i,
    input wire logic [7:0] pin_o_i,
    input wire logic [7:0] pin_oe_i,
    input wire logic [7:0] ext_en_i,
    input wire logic [7:0] ext_val_i,
    output logic [7:0] pin_lvl_o
);
    logic [7:0] wander_q = 8'h00;
    always_ff @(posedge clk_i) wander_q <= ~wander_q;
    assign pin_lvl_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_en_i & ext_val_i)
        | (~pin_oe_i & ~ext_en_i & wander_q);
endmodule // pad_model

// file: verif/tb_gpio_port.sv
// Purpose: self-checking bench of the gpio port
// Assumes: pad model resolves every wire
// Notes: random register and peripheral settings, then an interrupt sweep
`timescale 1ns/10ps
`include "gpio_port_consts.svh"
module tb_gpio_port;
    logic clk_i = 1'b0, reset_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, vec_fetch_i = 1'b0, irq_req_o;
    logic [1:0] addr_i = 2'h0;
    logic [7:0] wdata_i = 8'h00, rdata_o, pin_o, pin_oe_o, alt_in_o, pin_lvl, ext_val = 8'h00;
    logic [7:0] dat, dir, opt, rd, ae, oe, val, ext, lvl;
    gpio_port_pkg::alt_ctrl_s alt_i = '0, alt;
    int errors = 0, comparisons = 0, k;
    initial forever #10 clk_i = ~clk_i;
    gpio_port i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_lvl), .pin_o(pin_o),
        .pin_oe_o(pin_oe_o), .alt_i(alt_i), .alt_in_o(alt_in_o), .vec_fetch_i(vec_fetch_i),
        .irq_req_o(irq_req_o));
    pad_model i_pad (.clk_i(clk_i), .pin_o_i(pin_o), .pin_oe_i(pin_oe_o), .ext_en_i(8'hff),
        .ext_val_i(ext_val), .pin_lvl_o(pin_lvl));
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    function automatic logic [7:0] exp_oe(input logic [7:0] d, r, o, a, od, ov);
        return (a & ~(od & ov)) | (~a & r & (o | ~d));
    endfunction
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rdb(input logic [1:0] a, output logic [7:0] d);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(posedge clk_i);
        d = rdata_o;
    endtask
    task automatic end_sim;
        if (errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #400000;
        errors++;
        end_sim;
    end
    initial begin
        k = $urandom(32'h6341);
        repeat (20) @(posedge clk_i);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        for (k = 1; k < 4; k++) begin
            rdb(k[1:0], rd);
            chk("reset", rd, 8'h00);
        end
        for (k = 0; k < 40; k++) begin
            dat = $urandom;
            dir = $urandom;
            opt = $urandom;
            ext = $urandom;
            alt = {$urandom, $urandom};
            alt.enable = (k < 20) ? 8'h00 : alt.enable & ~(~dir & opt);
            ae = alt.enable & alt.out_en;
            oe = exp_oe(dat, dir, opt, ae, alt.open_drain, alt.out_val);
            lvl = (oe & ((ae & alt.out_val) | (~ae & dat))) | (~oe & ext);
            val = (~dir & ae & alt.out_val) | (~(~dir & ae) & lvl);
            // functions off while the mode changes, so no interrupt pin sees one
            alt_i <= '0;
            ext_val <= ext;
            wr(`GPIO_OFS_DATA, dat);
            wr(`GPIO_OFS_DIR, dir);
            wr(`GPIO_OFS_OPT, opt);
            alt_i <= alt;
            rdb(`GPIO_OFS_DIR, rd);
            chk("dir", rd, dir);
            rdb(`GPIO_OFS_OPT, rd);
            chk("opt", rd, opt);
            rdb(`GPIO_OFS_DATA, rd);
            chk("data", rd, val);
            chk("oe", pin_oe_o, oe);
            chk("drive", pin_oe_o & pin_o, oe & ((ae & alt.out_val) | (~ae & dat)));
            chk("alt_in", alt_in_o, (dir & dat) | (~dir & lvl));
        end
        alt_i <= '0;
        ext_val <= 8'hff;
        wr(`GPIO_OFS_DIR, 8'h00);
        wr(`GPIO_OFS_OPT, 8'h03);
        repeat (6) @(posedge clk_i);
        for (k = 0; k < 4; k++) begin
            wr(`GPIO_OFS_SENS, {6'h00, k[1:0]});
            rdb(`GPIO_OFS_SENS, rd);
            chk("sens", rd, {6'h00, k[1:0]});
            chk("idle", {7'h00, irq_req_o}, 8'h00);
            ext_val[0] <= 1'b0;
            repeat (6) @(posedge clk_i);
            chk("fall", {7'h00, irq_req_o}, {7'h00, k != 1});
            vec_fetch_i <= 1'b1;
            @(posedge clk_i);
            vec_fetch_i <= 1'b0;
            ext_val[1] <= 1'b0;
            repeat (6) @(posedge clk_i);
            ext_val[0] <= 1'b1;
            repeat (6) @(posedge clk_i);
            if (k != 0) chk("mask", {7'h00, irq_req_o}, 8'h00);
            ext_val[1] <= 1'b1;
            repeat (6) @(posedge clk_i);
            chk("rise", {7'h00, irq_req_o}, {7'h00, k != 2});
        end
        end_sim;
    end
endmodule // tb_gpio_port
